// ---- logic/bpc_regs.svh ----
// Register map, field positions, reset values and polynomial constants
// for the byte-parallel CRC unit. Included by the design files only.
`ifndef BPC_REGS_SVH
`define BPC_REGS_SVH

`define BPC_ADDR_W          2
`define BPC_DATA_W          16

`define BPC_OFF_CONTROL     2'h0
`define BPC_OFF_BYTE_IN     2'h1
`define BPC_OFF_RESULT      2'h2

`define BPC_CTL_CLEAR_BIT   7
`define BPC_CTL_ORDER_BIT   2
`define BPC_CTL_POLY_HI     1
`define BPC_CTL_POLY_LO     0

`define BPC_CTL_RESET       1'b0
`define BPC_POLY_RESET      2'h0
`define BPC_BYTE_RESET      8'h00
`define BPC_RESULT_RESET    16'h0000
`define BPC_RDATA_RESET     16'h0000
`define BPC_UNMAPPED_READ   16'h0000

`define BPC_MASK8           16'h00ff
`define BPC_MASK16          16'hffff
`define BPC_TOP8            4'h7
`define BPC_TOP16           4'hf

`define BPC_POLY8_NORM      16'h0007
`define BPC_POLY8_REFL      16'h00e0
`define BPC_POLY16A_NORM    16'h8005
`define BPC_POLY16A_REFL    16'ha001
`define BPC_POLY16B_NORM    16'h1021
`define BPC_POLY16B_REFL    16'h8408

`endif

// ---- logic/bpc_pkg.sv ----
// Types shared by the CRC unit modules.
// Assumes nothing of its surroundings.
`default_nettype none

package bpc_pkg;

  typedef enum logic [1:0]
  {
    BPC_POLY_RSVD  = 2'b00,
    BPC_POLY_CRC8  = 2'b01,
    BPC_POLY_CRC16 = 2'b10,
    BPC_POLY_CCITT = 2'b11
  } bpc_poly_t;

  typedef enum logic
  {
    BPC_ORDER_LSB = 1'b0,
    BPC_ORDER_MSB = 1'b1
  } bpc_order_t;

endpackage

`default_nettype wire

// ---- logic/bpc_step_if.sv ----
// Link between the register bank and the byte folding network.
// Purely combinational; the owner of the result register drives crc_in.
`default_nettype none

interface bpc_step_if;
  import bpc_pkg::*;

  logic [15:0] crc_in;
  logic [7:0]  data;
  bpc_order_t  order;
  bpc_poly_t   poly;
  logic [15:0] crc_out;

  modport calc
  (
    input  crc_in,
    input  data,
    input  order,
    input  poly,
    output crc_out
  );

  modport ctrl
  (
    output crc_in,
    output data,
    output order,
    output poly,
    input  crc_out
  );
endinterface

`default_nettype wire

// ---- logic/bpc_byte_step.sv ----
// Folds one byte into a running CRC in a single combinational pass.
// Result is only meaningful for polynomial codes other than 00.
`default_nettype none
`include "bpc_regs.svh"

module bpc_byte_step
(
  bpc_step_if.calc step
);
  import bpc_pkg::*;

  logic [15:0] poly_norm;
  logic [15:0] poly_refl;
  logic [15:0] width_mask;
  logic [3:0]  top_bit;
  logic [15:0] chain [0:8];

  always_comb
  begin
    poly_norm  = `BPC_POLY16B_NORM;
    poly_refl  = `BPC_POLY16B_REFL;
    width_mask = `BPC_MASK16;
    top_bit    = `BPC_TOP16;
    case (step.poly)
      BPC_POLY_CRC8:
      begin
        poly_norm  = `BPC_POLY8_NORM;
        poly_refl  = `BPC_POLY8_REFL;
        width_mask = `BPC_MASK8;
        top_bit    = `BPC_TOP8;
      end
      BPC_POLY_CRC16:
      begin
        poly_norm = `BPC_POLY16A_NORM;
        poly_refl = `BPC_POLY16A_REFL;
      end
      default:
      begin
        poly_norm = `BPC_POLY16B_NORM;
        poly_refl = `BPC_POLY16B_REFL;
      end
    endcase
  end

  assign chain[0] = step.crc_in & width_mask;

  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_bit
      logic        din;
      logic        fb;
      logic [15:0] nxt;
      always_comb
      begin
        if (step.order == BPC_ORDER_LSB)
        begin
          din = step.data[i];
          fb  = chain[i][0] ^ din;
          nxt = (chain[i] >> 1) ^ (fb ? poly_refl : `BPC_RESULT_RESET);
        end
        else
        begin
          din = step.data[7 - i];
          fb  = chain[i][top_bit] ^ din;
          nxt = ((chain[i] << 1) ^ (fb ? poly_norm : `BPC_RESULT_RESET)) & width_mask;
        end
      end
      assign chain[i + 1] = nxt;
    end
  endgenerate

  assign step.crc_out = chain[8];
endmodule

`default_nettype wire

// ---- logic/bpc_read_mux.sv ----
// Registered read port: selects one register by address and holds it
// for exactly the cycle after the read strobe, zero otherwise.
`default_nettype none
`include "bpc_regs.svh"

module bpc_read_mux
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   arst_n_i,
  input  wire logic [`BPC_ADDR_W-1:0] addr_i,
  input  wire logic                   rd_stb_i,
  input  wire logic [7:0]             control_i,
  input  wire logic [7:0]             byte_in_i,
  input  wire logic [15:0]            result_i,
  output logic      [15:0]            rdata_o
);
  logic [15:0] rdata;
  logic [15:0] next_rdata;

  always_comb
  begin
    next_rdata = `BPC_RDATA_RESET;
    if (rd_stb_i)
    begin
      case (addr_i)
        `BPC_OFF_CONTROL: next_rdata = {8'h00, control_i};
        `BPC_OFF_BYTE_IN: next_rdata = {8'h00, byte_in_i};
        `BPC_OFF_RESULT:  next_rdata = result_i;
        default:          next_rdata = `BPC_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata <= `BPC_RDATA_RESET;
    else
      rdata <= next_rdata;
  end

  assign rdata_o = rdata;
endmodule

`default_nettype wire

// ---- logic/bpc_crc_unit.sv ----
// Byte-parallel CRC unit: control, byte input and result registers on a
// plain strobe port. Assumes strobes are single-cycle and never overlap.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`default_nettype none
`include "bpc_regs.svh"

module bpc_crc_unit
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   arst_n_i,
  input  wire logic [`BPC_ADDR_W-1:0] addr_i,
  input  wire logic [`BPC_DATA_W-1:0] wdata_i,
  input  wire logic                   wr_stb_i,
  input  wire logic                   rd_stb_i,
  output logic      [`BPC_DATA_W-1:0] rdata_o,
  output bpc_pkg::bpc_poly_t          poly_sel_o,
  output bpc_pkg::bpc_order_t         order_sel_o
);
  import bpc_pkg::*;

  bpc_order_t  order;
  bpc_poly_t   poly;
  logic [7:0]  byte_in;
  logic [15:0] result;

  bpc_order_t  next_order;
  bpc_poly_t   next_poly;
  logic [7:0]  next_byte_in;
  logic [15:0] next_result;

  logic        wr_control;
  logic        wr_byte;
  logic        wr_result;
  logic [7:0]  control_view;

  bpc_step_if step ();

  assign wr_control = wr_stb_i && (addr_i == `BPC_OFF_CONTROL);
  assign wr_byte    = wr_stb_i && (addr_i == `BPC_OFF_BYTE_IN);
  assign wr_result  = wr_stb_i && (addr_i == `BPC_OFF_RESULT);

  // Fold the byte being written, not the stored one
  assign step.crc_in = result;
  assign step.data   = wdata_i[7:0];
  assign step.order  = order;
  assign step.poly   = poly;

  bpc_byte_step u_step
  (
    .step (step.calc)
  );

  always_comb
  begin
    next_order   = order;
    next_poly    = poly;
    next_byte_in = byte_in;
    next_result  = result;
    if (wr_control)
    begin
      next_order = bpc_order_t'(wdata_i[`BPC_CTL_ORDER_BIT]);
      next_poly  = bpc_poly_t'(wdata_i[`BPC_CTL_POLY_HI:`BPC_CTL_POLY_LO]);
      if (wdata_i[`BPC_CTL_CLEAR_BIT])
        next_result = `BPC_RESULT_RESET;
    end
    if (wr_byte)
    begin
      next_byte_in = wdata_i[7:0];
      // running fold; reserved code leaves result untouched
      if (poly != BPC_POLY_RSVD)
        next_result = step.crc_out;
    end
    if (wr_result)
      next_result = wdata_i;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      order   <= bpc_order_t'(`BPC_CTL_RESET);
      poly    <= bpc_poly_t'(`BPC_POLY_RESET);
      byte_in <= `BPC_BYTE_RESET;
      result  <= `BPC_RESULT_RESET;
    end
    else
    begin
      order   <= next_order;
      poly    <= next_poly;
      byte_in <= next_byte_in;
      result  <= next_result;
    end
  end

  // reserved and clear bits read zero
  assign control_view = {5'h00, order, poly};

  bpc_read_mux u_rd
  (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .addr_i    (addr_i),
    .rd_stb_i  (rd_stb_i),
    .control_i (control_view),
    .byte_in_i (byte_in),
    .result_i  (result),
    .rdata_o   (rdata_o)
  );

  assign poly_sel_o  = poly;
  assign order_sel_o = order;
endmodule

`default_nettype wire

// ---- sim/bpc_crc_chk.sv ----
// Port-level checker for the CRC unit, bound to its top module.
// Assumes single-cycle strobes that never overlap.
`default_nettype none

module bpc_crc_chk
(
  input wire logic                clk_sys_i,
  input wire logic                arst_n_i,
  input wire logic [1:0]          addr_i,
  input wire logic [15:0]         wdata_i,
  input wire logic                wr_stb_i,
  input wire logic                rd_stb_i,
  input wire logic [15:0]         rdata_o,
  input wire bpc_pkg::bpc_poly_t  poly_sel_o,
  input wire bpc_pkg::bpc_order_t order_sel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  property p_rd_idle;
    !$past(rd_stb_i) |-> rdata_o == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_ctl_poly;
    wr_stb_i && addr_i == 2'h0 |=> poly_sel_o == $past(wdata_i[1:0]);
  endproperty
  a_ctl_poly: assert property (p_ctl_poly) else $error("poly code not taken");
  property p_ctl_order;
    wr_stb_i && addr_i == 2'h0 |=> order_sel_o == $past(wdata_i[2]);
  endproperty
  a_ctl_order: assert property (p_ctl_order) else $error("bit order not taken");
  property p_rsvd;
    rd_stb_i && addr_i == 2'h0 |=> rdata_o[15:3] == 13'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("control upper bits not zero");
  property p_ctl_read;
    rd_stb_i && addr_i == 2'h0 |=> rdata_o[2:0] == {order_sel_o, poly_sel_o};
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control readback differs");
  property p_hold;
    !(wr_stb_i && addr_i == 2'h0) |=> $stable(poly_sel_o) && $stable(order_sel_o);
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed without write");
  property p_clr;
    wr_stb_i && addr_i == 2'h0 && wdata_i[7] ##1 rd_stb_i && addr_i == 2'h2 |=> rdata_o == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("result not cleared");
  property p_byte_rd;
    wr_stb_i && addr_i == 2'h1 ##1 rd_stb_i && addr_i == 2'h1 |=> rdata_o == {8'h00, $past(wdata_i[7:0], 2)};
  endproperty
  a_byte_rd: assert property (p_byte_rd) else $error("byte input readback differs");
endmodule

bind bpc_crc_unit bpc_crc_chk bpc_crc_chk_inst
(
  .clk_sys_i   (clk_sys_i),
  .arst_n_i    (arst_n_i),
  .addr_i      (addr_i),
  .wdata_i     (wdata_i),
  .wr_stb_i    (wr_stb_i),
  .rd_stb_i    (rd_stb_i),
  .rdata_o     (rdata_o),
  .poly_sel_o  (poly_sel_o),
  .order_sel_o (order_sel_o)
);

`default_nettype wire

// ---- sim/bpc_crc_unit_bench.sv ----
// Self-checking bench for the CRC unit against an integer CRC model.
// Drives the register port directly; no other parties.
`default_nettype none

module bpc_crc_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import bpc_pkg::*;

  logic        clk_sys_i = 1'b0;
  logic        arst_n_i  = 1'b0;
  logic [1:0]  addr_i    = 2'h0;
  logic [15:0] wdata_i   = 16'h0000;
  logic        wr_stb_i  = 1'b0;
  logic        rd_stb_i  = 1'b0;
  logic [15:0] rdata_o;
  bpc_poly_t   poly_sel_o;
  bpc_order_t  order_sel_o;
  int          miscompares = 0;
  int          cmp_count   = 0;
  logic [31:0] seed = 32'h9783;
  int          m, b, n, crc;

  bpc_crc_unit bpc_crc_unit_inst
  (
    .clk_sys_i   (clk_sys_i),
    .arst_n_i    (arst_n_i),
    .addr_i      (addr_i),
    .wdata_i     (wdata_i),
    .wr_stb_i    (wr_stb_i),
    .rd_stb_i    (rd_stb_i),
    .rdata_o     (rdata_o),
    .poly_sel_o  (poly_sel_o),
    .order_sel_o (order_sel_o)
  );

  initial forever #12.5 clk_sys_i = ~clk_sys_i;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // bit 0 first reflected, bit 7 first normal
  function automatic int step(input int c, input int d, input int p, input int o);
    int g, w, fb;
    g = o ? (p == 1 ? 'h07 : p == 2 ? 'h8005 : 'h1021) : (p == 1 ? 'he0 : p == 2 ? 'ha001 : 'h8408);
    w = (p == 1) ? 8 : 16;
    for (int i = 0; i < 8; i++)
    begin
      if (o)
      begin
        fb = ((c >> (w - 1)) ^ (d >> (7 - i))) & 1;
        c = (c << 1) & ((1 << w) - 1);
      end
      else
      begin
        fb = (c ^ (d >> i)) & 1;
        c = c >> 1;
      end
      if (fb)
        c = c ^ g;
    end
    return c;
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Four-state compare so an unknown never slips through
  task automatic cmp(input logic [15:0] got, input logic [15:0] e);
    cmp_count++;
    if (got !== e)
    begin
      $display("ERROR t=%0t exp=%h got=%h", $time, e, got);
      miscompares++;
    end
  endtask

  // Entered and left just after a rising edge
  // Write strobe stays high on return; next rd call or caller lowers it
  task automatic wr(input logic [1:0] a, input int d);
    addr_i   <= a;
    wdata_i  <= d[15:0];
    wr_stb_i <= 1'b1;
    rd_stb_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic rd(input logic [1:0] a, input int e);
    addr_i   <= a;
    rd_stb_i <= 1'b1;
    wr_stb_i <= 1'b0;
    @(posedge clk_sys_i);
    rd_stb_i <= 1'b0;
    @(negedge clk_sys_i);
    cmp(rdata_o, e[15:0]);
    @(posedge clk_sys_i);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares++;
    finish_test();
  end

  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(2'h0, 0);
    rd(2'h2, 0);
    rd(2'h3, 0);
    wr(2'h2, 'h1234);
    rd(2'h2, 'h1234);
    wr(2'h0, 0);
    wr(2'h1, 'h5a);
    rd(2'h1, 'h5a);
    rd(2'h2, 'h1234);
    for (int p = 1; p < 4; p++)
      for (int o = 0; o < 2; o++)
      begin
        seed = xs(seed);
        wr(2'h2, seed[15:0]);
        wr(2'h0, 'h80 | (o << 2) | p);
        rd(2'h2, 0);
        cmp({13'h0000, order_sel_o, poly_sel_o}, 16'((o << 2) | p));
        m = 0;
        seed = xs(seed);
        n = 1 + seed % 6;
        for (int k = 0; k < n; k++)
        begin
          seed = xs(seed);
          b = seed & 'hff;
          wr(2'h1, b);
          m = step(m, b, p, o);
        end
        rd(2'h2, m);
        crc = m;
        if (p == 1)
          wr(2'h1, crc);
        else if (o)
        begin
          wr(2'h1, crc >> 8);
          wr(2'h1, crc & 'hff);
        end
        else
        begin
          wr(2'h1, crc & 'hff);
          wr(2'h1, crc >> 8);
        end
        rd(2'h2, 0);
        rd(2'h0, (o << 2) | p);
      end
    // Mid-run reset with non-zero state
    wr(2'h2, 16'hbeef);
    wr_stb_i <= 1'b0;
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(2'h0, 0);
    rd(2'h2, 0);
    finish_test();
  end
endmodule

`default_nettype wire
